// *** design/timer8_defines.vh ***
`ifndef TIMER8_DEFINES_VH
`define TIMER8_DEFINES_VH

// register offsets
`define OFS_CONTROL 8'h00
`define OFS_COUNT 8'h01
`define OFS_COMPARE 8'h02
`define OFS_ASYNC 8'h03
`define OFS_FLAGS 8'h04
`define OFS_MASK 8'h05

// control register fields
`define CTL_CS_LSB 0
`define CTL_CS_MSB 2
`define CTL_WGM_LSB 3
`define CTL_WGM_MSB 4
`define CTL_COM_LSB 5
`define CTL_COM_MSB 6
`define CTL_FORCE_BIT 7

// async, flag and mask fields
`define ASYNC_SEL_BIT 0
`define FLAG_OVF_BIT 0
`define FLAG_CMP_BIT 1

// reset values
`define RST_CONTROL 8'h00
`define RST_COUNT 8'h00
`define RST_COMPARE 8'h00
`define RST_FLAGS 2'h0
`define RST_MASK 2'h0

// counter extremes
`define CNT_BOTTOM 8'h00
`define CNT_MAX 8'hff

// waveform modes
`define MODE_NORMAL 2'h0
`define MODE_PHASE 2'h1
`define MODE_CTC 2'h2
`define MODE_FAST 2'h3

// output actions
`define COM_NONE 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3

// prescaler masks: tick when masked bits of the prescaler are all ones
`define PRESC_MASK_1 10'h000
`define PRESC_MASK_8 10'h007
`define PRESC_MASK_32 10'h01f
`define PRESC_MASK_64 10'h03f
`define PRESC_MASK_128 10'h07f
`define PRESC_MASK_256 10'h0ff
`define PRESC_MASK_1024 10'h3ff

`endif

// *** design/timer8_single_compare_pwm.v ***
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_defines.vh"

module timer8_single_compare_pwm (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // register port
    input wire [7:0] addr_i,
    input wire [7:0] wr_data_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rd_data_o,
    // interrupt requests and service acknowledges
    output reg irq_overflow_o,
    output reg irq_compare_o,
    input wire ack_overflow_i,
    input wire ack_compare_i,
    // crystal oscillator pins
    input wire crystal_pin_in_i,
    output reg crystal_pin_out_o,
    // compare output pin
    output reg compare_output_o,
    output reg compare_output_oe_o
);

    // ************************************************************
    // registers
    // ************************************************************
    reg [7:0] control_q;
    reg async_sel_q;
    reg [1:0] mask_q;
    reg [1:0] flag_q;
    reg [1:0] flag_d;
    reg [7:0] count_q;
    reg [7:0] count_d;
    reg [7:0] cmp_active_q;
    reg [7:0] cmp_active_d;
    reg [7:0] cmp_buf_q;
    reg down_q;
    reg down_d;
    reg block_q;
    reg oc_q;
    reg oc_d;
    reg [9:0] presc_q;
    reg xtal_meta_q;
    reg xtal_sync_q;
    reg xtal_prev_q;

    wire [2:0] clock_source_sel;
    wire [1:0] waveform_mode_sel;
    wire [1:0] compare_output_action;
    wire pwm_mode;
    wire wr_control;
    wire wr_count;
    wire wr_compare;
    wire wr_flags;
    wire force_strobe;
    wire base_tick;
    reg [9:0] presc_mask;
    wire timer_tick;
    wire match;
    wire match_hit;
    wire at_max;
    wire at_bottom;

    assign clock_source_sel = control_q[`CTL_CS_MSB:`CTL_CS_LSB];
    assign waveform_mode_sel = control_q[`CTL_WGM_MSB:`CTL_WGM_LSB];
    assign compare_output_action = control_q[`CTL_COM_MSB:`CTL_COM_LSB];
    assign pwm_mode = (waveform_mode_sel == `MODE_PHASE) || (waveform_mode_sel == `MODE_FAST);

    assign wr_control = wr_i && (addr_i == `OFS_CONTROL);
    assign wr_count = wr_i && (addr_i == `OFS_COUNT);
    assign wr_compare = wr_i && (addr_i == `OFS_COMPARE);
    assign wr_flags = wr_i && (addr_i == `OFS_FLAGS);
    assign force_strobe = wr_control && wr_data_i[`CTL_FORCE_BIT] && !pwm_mode;

    // ************************************************************
    // crystal oscillator and tick source
    // ************************************************************
    // the crystal pin is asynchronous: two flops before any use
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xtal_meta_q <= 1'b0;
            xtal_sync_q <= 1'b0;
            xtal_prev_q <= 1'b0;
            crystal_pin_out_o <= 1'b1;
        end else begin
            xtal_meta_q <= crystal_pin_in_i;
            xtal_sync_q <= xtal_meta_q;
            xtal_prev_q <= xtal_sync_q;
            // inverting stage keeps the external crystal loop running
            crystal_pin_out_o <= ~xtal_sync_q;
        end
    end

    // io clock by default, crystal when selected
    assign base_tick = async_sel_q ? (xtal_sync_q && !xtal_prev_q) : 1'b1;

    always @* begin
        case (clock_source_sel)
            3'h2: presc_mask = `PRESC_MASK_8;
            3'h3: presc_mask = `PRESC_MASK_32;
            3'h4: presc_mask = `PRESC_MASK_64;
            3'h5: presc_mask = `PRESC_MASK_128;
            3'h6: presc_mask = `PRESC_MASK_256;
            3'h7: presc_mask = `PRESC_MASK_1024;
            default: presc_mask = `PRESC_MASK_1;
        endcase
    end

    // no source selected stops the counter
    assign timer_tick = (clock_source_sel != 3'h0) && base_tick && ((presc_q & presc_mask) == presc_mask);

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            presc_q <= 10'h000;
        end else if (base_tick) begin
            presc_q <= presc_q + 10'h001;
        end
    end

    // ************************************************************
    // comparator
    // ************************************************************
    // 8-bit equality compare
    assign match = (count_q == cmp_active_q);
    assign match_hit = match && !block_q;
    assign at_max = (count_q == `CNT_MAX);
    assign at_bottom = (count_q == `CNT_BOTTOM);

    // ************************************************************
    // counter unit
    // ************************************************************
    always @* begin
        count_d = count_q;
        down_d = down_q;
        if (waveform_mode_sel != `MODE_PHASE) begin
            down_d = 1'b0;
        end
        if (timer_tick) begin
            case (waveform_mode_sel)
                `MODE_CTC: begin
                    if (match) begin
                        count_d = `CNT_BOTTOM;
                    end else begin
                        count_d = count_q + 8'h01;
                    end
                end
                `MODE_PHASE: begin
                    // dual slope between bottom and max
                    if (!down_q) begin
                        if (at_max) begin
                            down_d = 1'b1;
                            count_d = count_q - 8'h01;
                        end else begin
                            count_d = count_q + 8'h01;
                        end
                    end else begin
                        if (at_bottom) begin
                            down_d = 1'b0;
                            count_d = count_q + 8'h01;
                        end else begin
                            count_d = count_q - 8'h01;
                        end
                    end
                end
                default: begin
                    // normal wraps, fast PWM single slope
                    count_d = count_q + 8'h01;
                end
            endcase
        end
        if (wr_count) begin
            count_d = wr_data_i;
        end
    end

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= `RST_COUNT;
            down_q <= 1'b0;
            block_q <= 1'b0;
        end else begin
            count_q <= count_d;
            down_q <= down_d;
            // block lasts until the next tick, stopped or not
            if (wr_count) begin
                block_q <= 1'b1;
            end else if (timer_tick) begin
                block_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // compare register and buffer
    // ************************************************************
    always @* begin
        cmp_active_d = cmp_active_q;
        // load at max: bottom of fast PWM, top of phase correct
        if (pwm_mode && timer_tick && at_max) begin
            cmp_active_d = cmp_buf_q;
        end
        if (wr_compare && !pwm_mode) begin
            cmp_active_d = wr_data_i;
        end
    end

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_active_q <= `RST_COMPARE;
            cmp_buf_q <= `RST_COMPARE;
        end else begin
            cmp_active_q <= cmp_active_d;
            // buffer always follows writes; reads show the buffer in PWM modes, the active value otherwise
            if (wr_compare) begin
                cmp_buf_q <= wr_data_i;
            end
        end
    end

    // ************************************************************
    // waveform generator
    // ************************************************************
    always @* begin
        // state held unless an action applies
        oc_d = oc_q;
        case (waveform_mode_sel)
            `MODE_FAST: begin
                // clear/set actions only; bit 0 inverts, match beats wrap
                if (timer_tick && (match_hit || at_max) && compare_output_action[1]) begin
                    oc_d = !match_hit ^ compare_output_action[0];
                end
            end
            `MODE_PHASE: begin
                // up-count match clears, down-count match sets; bit 0 inverts
                if (timer_tick && match_hit && compare_output_action[1]) begin
                    oc_d = down_q ^ compare_output_action[0];
                end
            end
            default: begin
                // forced match acts like a real one
                if ((timer_tick && match_hit) || force_strobe) begin
                    case (force_strobe ? wr_data_i[`CTL_COM_MSB:`CTL_COM_LSB] : compare_output_action)
                        `COM_TOGGLE: oc_d = !oc_q;
                        `COM_CLEAR: oc_d = 1'b0;
                        `COM_SET: oc_d = 1'b1;
                        default: oc_d = oc_q;
                    endcase
                end
            end
        endcase
    end

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oc_q <= 1'b0;
            compare_output_o <= 1'b0;
            compare_output_oe_o <= 1'b0;
        end else begin
            oc_q <= oc_d;
            compare_output_o <= oc_d;
            // pin overridden whenever any action bit is set
            compare_output_oe_o <= (compare_output_action != `COM_NONE);
        end
    end

    // ************************************************************
    // flags and interrupts
    // ************************************************************
    always @* begin
        flag_d = flag_q;
        // clears first so that a same-cycle set wins
        if (wr_flags) begin
            flag_d = flag_q & ~wr_data_i[1:0];
        end
        if (ack_overflow_i) begin
            flag_d[`FLAG_OVF_BIT] = 1'b0;
        end
        if (ack_compare_i) begin
            flag_d[`FLAG_CMP_BIT] = 1'b0;
        end
        // set on the tick after match; force never sets it
        if (timer_tick && match_hit) begin
            flag_d[`FLAG_CMP_BIT] = 1'b1;
        end
        if (timer_tick) begin
            if (waveform_mode_sel == `MODE_PHASE) begin
                if (at_bottom && down_q) begin
                    flag_d[`FLAG_OVF_BIT] = 1'b1;
                end
            end else if (at_max && !(waveform_mode_sel == `MODE_CTC && match)) begin
                // set as the count becomes zero
                flag_d[`FLAG_OVF_BIT] = 1'b1;
            end
        end
    end

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_q <= `RST_FLAGS;
            irq_overflow_o <= 1'b0;
            irq_compare_o <= 1'b0;
        end else begin
            flag_q <= flag_d;
            // each request gated by its mask bit
            irq_overflow_o <= flag_d[`FLAG_OVF_BIT] && mask_q[`FLAG_OVF_BIT];
            irq_compare_o <= flag_d[`FLAG_CMP_BIT] && mask_q[`FLAG_CMP_BIT];
        end
    end

    // ************************************************************
    // register port
    // ************************************************************
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            control_q <= `RST_CONTROL;
            async_sel_q <= 1'b0;
            mask_q <= `RST_MASK;
        end else begin
            if (wr_control) begin
                // the force bit is a strobe and is never stored
                control_q <= {1'b0, wr_data_i[6:0]};
            end
            if (wr_i && addr_i == `OFS_ASYNC) begin
                async_sel_q <= wr_data_i[`ASYNC_SEL_BIT];
            end
            if (wr_i && addr_i == `OFS_MASK) begin
                mask_q <= wr_data_i[1:0];
            end
        end
    end

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `OFS_CONTROL: rd_data_o <= control_q;
                `OFS_COUNT: rd_data_o <= count_q;
                `OFS_COMPARE: rd_data_o <= pwm_mode ? cmp_buf_q : cmp_active_q;
                `OFS_ASYNC: rd_data_o <= {7'h00, async_sel_q};
                `OFS_FLAGS: rd_data_o <= {6'h00, flag_q};
                `OFS_MASK: rd_data_o <= {6'h00, mask_q};
                default: rd_data_o <= 8'h00;
            endcase
        end else begin
            rd_data_o <= 8'h00;
        end
    end
endmodule // timer8_single_compare_pwm

`default_nettype wire

// *** tb/timer8_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer8_checker (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // register port
    input wire [7:0] addr_i,
    input wire [7:0] wr_data_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rd_data_o,
    // pins
    input wire irq_overflow_o,
    input wire irq_compare_o,
    input wire crystal_pin_in_i,
    input wire crystal_pin_out_o,
    input wire compare_output_o,
    input wire compare_output_oe_o
);
    // ****
    // shadow of written settings
    // ****
    reg ovf_en_q;
    reg cmp_en_q;
    reg hold_ok_q;
    reg [2:0] cs_q;
    reg [1:0] act_q;
    reg [7:0] cnt_q;
    // count is only predictable when it was written while stopped
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovf_en_q <= 1'b0;
            cmp_en_q <= 1'b0;
            hold_ok_q <= 1'b1;
            cs_q <= 3'h0;
            act_q <= 2'h0;
            cnt_q <= 8'h00;
        end else if (wr_i) begin
            if (addr_i == 8'h05) begin
                ovf_en_q <= wr_data_i[0];
                cmp_en_q <= wr_data_i[1];
            end
            if (addr_i == 8'h00) begin
                cs_q <= wr_data_i[2:0];
                act_q <= wr_data_i[6:5];
                if (wr_data_i[2:0] != 3'h0) begin
                    hold_ok_q <= 1'b0;
                end
            end
            if (addr_i == 8'h01) begin
                cnt_q <= wr_data_i;
                hold_ok_q <= (cs_q == 3'h0);
            end
        end
    end
    // ****
    // properties
    // ****
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_read_quiet:
        assert property (!$past(rd_i) || $past(addr_i) > 8'h05 |-> rd_data_o == 8'h00) else $error("read data not zero");
    a_force_reads0:
        assert property (rd_i && addr_i == 8'h00 |=> rd_data_o[7] == 1'b0) else $error("force bit read one");
    a_mask_read:
        assert property (rd_i && addr_i == 8'h05 |=> rd_data_o == {6'h00, cmp_en_q, ovf_en_q}) else $error("mask readback");
    a_stop_holds:
        assert property (rd_i && addr_i == 8'h01 && hold_ok_q |=> rd_data_o == cnt_q) else $error("stopped count moved");
    a_ovf_gate:
        assert property (irq_overflow_o |-> $past(ovf_en_q)) else $error("overflow request unmasked");
    a_cmp_gate:
        assert property (irq_compare_o |-> $past(cmp_en_q)) else $error("compare request unmasked");
    a_quiet_output:
        assert property (act_q == 2'h0 && $past(act_q) == 2'h0 |-> $stable(compare_output_o)) else $error("output moved");
    a_oe_action:
        assert property (act_q == $past(act_q) |-> compare_output_oe_o == (act_q != 2'h0)) else $error("pin override");
    a_xtal_invert:
        assert property ($stable(crystal_pin_in_i) [*4] |-> crystal_pin_out_o != crystal_pin_in_i) else $error("crystal out");
    c_compare_irq: cover property (irq_compare_o);
    c_overflow_irq: cover property ($rose(irq_overflow_o));
    c_pin_driven: cover property (compare_output_oe_o && compare_output_o);
endmodule // timer8_checker

bind timer8_single_compare_pwm timer8_checker u_checker (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rd_data_o(rd_data_o),
    .irq_overflow_o(irq_overflow_o),
    .irq_compare_o(irq_compare_o),
    .crystal_pin_in_i(crystal_pin_in_i),
    .crystal_pin_out_o(crystal_pin_out_o),
    .compare_output_o(compare_output_o),
    .compare_output_oe_o(compare_output_oe_o)
);
`default_nettype wire

// *** tb/timer8_single_compare_pwm_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer8_single_compare_pwm_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ack_ovf = 1'b0;
    logic ack_cmp = 1'b0;
    logic xtal_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] v;
    wire [7:0] rdata;
    wire irq_ovf;
    wire irq_cmp;
    wire xtal_out;
    wire pin;
    wire pin_oe;
    int n_errors = 0;
    int check_count = 0;
    int n;
    int div_tab [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    // control byte, expected pin
    logic [15:0] force_tab [6] = '{16'he001, 16'hc000, 16'ha001, 16'h8001, 16'h1801, 16'hd801};

    always #25 clk = ~clk;

    timer8_single_compare_pwm dut (
        .ref_clk_i(clk),
        .rst_n_i(rst_n),
        .addr_i(addr),
        .wr_data_i(wdata),
        .wr_i(wr),
        .rd_i(rd),
        .rd_data_o(rdata),
        .irq_overflow_o(irq_ovf),
        .irq_compare_o(irq_cmp),
        .ack_overflow_i(ack_ovf),
        .ack_compare_i(ack_cmp),
        .crystal_pin_in_i(xtal_in),
        .crystal_pin_out_o(xtal_out),
        .compare_output_o(pin),
        .compare_output_oe_o(pin_oe)
    );
    // ****
    // tasks
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
        rreg(a, v);
        check(v, e);
    endtask
    // start, wait, then stop keeping mode and action
    task automatic run(input logic [7:0] ctl, input int c);
        wreg(8'h00, ctl);
        repeat (c) @(posedge clk);
        wreg(8'h00, ctl & 8'h78);
    endtask
    task automatic duty(input int span, output int hi);
        hi = 0;
        repeat (span) begin
            @(negedge clk);
            if (pin === 1'b1) begin
                hi++;
            end
        end
    endtask
    function automatic logic [7:0] in_range(input logic [10:0] x, input logic [10:0] lo, input logic [10:0] hi);
        return {7'h00, x >= lo && x <= hi};
    endfunction
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ****
    // tests
    // ****
    initial begin
        // tests need about 14,000 cycles; allow 40,000
        #2000000;
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk);
        check({7'h00, xtal_out}, 8'h01);
        rst_n <= 1'b1;
        for (int a = 0; a < 7; a++) expect_reg(8'(a), 8'h00);
        wreg(8'h01, 8'h55);
        expect_reg(8'h01, 8'h55);
        wreg(8'h02, 8'h10);
        expect_reg(8'h02, 8'h10);
        wreg(8'h05, 8'h03);
        expect_reg(8'h05, 8'h03);
        $display("test access done");
        // a count equal to compare must not match on the first tick
        wreg(8'h01, 8'h10);
        run(8'h01, 8);
        expect_reg(8'h04, 8'h00);
        wreg(8'h01, 8'h0e);
        run(8'h01, 8);
        expect_reg(8'h04, 8'h02);
        check({7'h00, irq_cmp}, 8'h01);
        @(posedge clk) ack_cmp <= 1'b1;
        @(posedge clk) ack_cmp <= 1'b0;
        expect_reg(8'h04, 8'h00);
        check({7'h00, irq_cmp}, 8'h00);
        $display("test match done");
        wreg(8'h01, 8'hfc);
        run(8'h01, 8);
        expect_reg(8'h04, 8'h01);
        check({7'h00, irq_ovf}, 8'h01);
        @(posedge clk) ack_ovf <= 1'b1;
        @(posedge clk) ack_ovf <= 1'b0;
        expect_reg(8'h04, 8'h00);
        wreg(8'h02, 8'h05);
        wreg(8'h01, 8'h00);
        run(8'h11, 40);
        rreg(8'h01, v);
        check({7'h00, v <= 8'h05}, 8'h01);
        expect_reg(8'h04, 8'h02);
        wreg(8'h04, 8'h02);
        expect_reg(8'h04, 8'h00);
        $display("test overflow and clear done");
        wreg(8'h01, 8'h33);
        foreach (force_tab[i]) begin
            wreg(8'h00, force_tab[i][15:8]);
            repeat (2) @(negedge clk);
            check({7'h00, pin}, force_tab[i][7:0]);
            check({7'h00, pin_oe}, {7'h00, |force_tab[i][14:13]});
        end
        expect_reg(8'h04, 8'h00);
        expect_reg(8'h01, 8'h33);
        $display("test force done");
        // buffered compare stays inactive until the wrap
        wreg(8'h01, 8'h38);
        wreg(8'h02, 8'h40);
        expect_reg(8'h02, 8'h40);
        run(8'h59, 12);
        expect_reg(8'h04, 8'h00);
        wreg(8'h00, 8'h59);
        repeat (300) @(posedge clk);
        duty(256, n);
        check(in_range(11'(n), 11'd64, 11'd66), 8'h01);
        expect_reg(8'h04, 8'h03);
        wreg(8'h00, 8'h58);
        wreg(8'h04, 8'h03);
        run(8'h49, 600);
        wreg(8'h00, 8'h49);
        duty(510, n);
        check(in_range(11'(n), 11'd126, 11'd130), 8'h01);
        expect_reg(8'h04, 8'h03);
        wreg(8'h00, 8'h00);
        $display("test pwm done");
        for (int s = 1; s < 8; s++) begin
            wreg(8'h01, 8'h00);
            run(8'(s), 8 * div_tab[s]);
            rreg(8'h01, v);
            check(in_range({3'h0, v}, 11'd7, 11'd11), 8'h01);
        end
        wreg(8'h03, 8'h01);
        expect_reg(8'h03, 8'h01);
        wreg(8'h01, 8'h00);
        wreg(8'h00, 8'h01);
        repeat (20) @(posedge clk);
        expect_reg(8'h01, 8'h00);
        repeat (10) begin
            repeat (4) @(posedge clk);
            xtal_in <= 1'b1;
            repeat (4) @(posedge clk);
            xtal_in <= 1'b0;
        end
        repeat (8) @(posedge clk);
        expect_reg(8'h01, 8'h0a);
        $display("test clock source done");
        end_sim();
    end
endmodule // timer8_single_compare_pwm_bench
`default_nettype wire
